//--- common/msc_pkg.sv
package msc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int RESET_MIN_NS   = 2000;
  // least time: round up to whole cycles
  localparam int RESET_MIN_CYC  =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W    = 6;
  localparam int INIT_MAX_MS    = 2000;
  // longest time: round down
  localparam int INIT_MAX_CYC   =
    INIT_MAX_MS * (1000000 / CLK_PERIOD_NS);
  localparam int INIT_CNT_W     = 26;
  localparam int INT_RELEASE_US = 500;
  localparam int INT_RELEASE_CYC =
    (INT_RELEASE_US * 1000) / CLK_PERIOD_NS;

  // status byte 2 layout
  localparam int          STATUS2_DNR_BIT = 0;
  localparam logic [7:0]  STATUS2_RESET   = 8'h01;

  // pin levels as seen at the connector
  localparam logic        PRESENT_LEVEL   = 1'b0;
  localparam logic        SYNC_RESET_VAL  = 1'b1;

  // slow pins, travelling together
  typedef struct packed {
    logic select_n;
    logic reset_n;
    logic low_power;
  } msc_pins_type;

  localparam msc_pins_type PINS_IDLE = '{
    select_n:  1'b1,
    reset_n:   1'b1,
    low_power: 1'b1
  };

  // sticky interrupt sources
  typedef struct packed {
    logic fault;
    logic complete;
  } msc_flags_type;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_INIT  = 3'b010,
    ST_READY = 3'b100
  } msc_state_type;

endpackage

//--- design/msc_pin_conditioner.sv
module msc_pin_conditioner
  import msc_pkg::*;
(
  input  wire logic         i_clk_sys,       // system clock
  input  wire logic         i_rst,           // async reset, high
  input  wire msc_pins_type i_pins,          // raw connector pins
  output msc_pins_type      o_pins,          // synchronised pins
  output logic              o_reset_hold,    // qualified reset active
  output logic              o_reset_release  // pulse at reset release
);

  localparam int W = $bits(msc_pins_type);

  logic [W-1:0]            meta;
  logic [W-1:0]            sync;
  logic [RESET_CNT_W-1:0]  cnt;
  logic [RESET_CNT_W-1:0]  next_cnt;
  logic                    next_hold;
  logic                    next_release;
  logic                    low;

  // two flops per pin; idle levels match the pull-ups
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_sync
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          meta[g] <= SYNC_RESET_VAL;
          sync[g] <= SYNC_RESET_VAL;
        end else begin
          meta[g] <= i_pins[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  assign o_pins = msc_pins_type'(sync);
  assign low    = ~o_pins.reset_n;

  // short lows never reach the hold flag
  always_comb begin
    next_cnt     = '0;
    next_hold    = o_reset_hold;
    next_release = 1'b0;
    if (low) begin
      next_cnt = cnt;
      if (cnt != RESET_CNT_W'(RESET_MIN_CYC + 1))
        next_cnt = cnt + RESET_CNT_W'(1);
      if (cnt == RESET_CNT_W'(RESET_MIN_CYC))
        next_hold = 1'b1;
    end else if (o_reset_hold) begin
      next_hold    = 1'b0;
      next_release = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt             <= '0;
      o_reset_hold    <= 1'b0;
      o_reset_release <= 1'b0;
    end else begin
      cnt             <= next_cnt;
      o_reset_hold    <= next_hold;
      o_reset_release <= next_release;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_hold_qualified;
    $rose(o_reset_hold) |-> $past(cnt) == RESET_CNT_W'(RESET_MIN_CYC);
  endproperty
  a_hold_qualified: assert property (p_hold_qualified)
    else $error("reset accepted before minimum pulse");

  property p_glitch_clears;
    !low |=> cnt == '0;
  endproperty
  a_glitch_clears: assert property (p_glitch_clears)
    else $error("reset pulse counter kept after high level");

  property p_release_edge;
    o_reset_release |-> $past(o_reset_hold) && !$past(low) && !o_reset_hold;
  endproperty
  a_release_edge: assert property (p_release_edge)
    else $error("release pulse not at rising edge of reset");

  property p_sync_lat;
    i_pins.low_power ##1 i_pins.low_power |=> o_pins.low_power;
  endproperty
  a_sync_lat: assert property (p_sync_lat)
    else $error("low power pin not passed after two flops");

endmodule

//--- design/msc_sideband.sv
// Contract
// - select low: answer addressed 2-wire transfers
// - select high: never drive data line
// - select pin has internal pull-up
// - qualified reset restores all settings default
// - init timing starts at reset rising edge
// - completion: interrupt with not-ready bit cleared
// - power-up posts completion without reset pulse
// - no override: pin high means low power
// - override: power-set bit chooses level
// - presence output tied low inside module
// - interrupt pulled low on fault or status
// - interrupt only pulled low or released
// - reset low must exceed two microseconds
// - not-ready in byte 2 bit 0, cleared
// - flags clear on read, release interrupt
module msc_sideband
  import msc_pkg::*;
#(
  parameter int INIT_LIMIT = INIT_MAX_CYC  // init deadline, cycles
)(
  input  wire logic         i_clk_sys,           // system clock
  input  wire logic         i_rst,               // async reset, high
  input  wire logic         i_module_select_pin_n, // select pin
  input  wire logic         i_module_reset_n,    // reset pin
  input  wire logic         i_low_power_request, // low power pin
  input  wire logic         i_twi_sda_pull,      // 2-wire core pulls sda
  input  wire logic         i_monitor_valid,     // monitor data valid
  input  wire logic         i_fault_event,       // fault flag set pulse
  input  wire logic         i_flag_read,         // host read of flags
  input  wire logic         i_power_override,    // override bit
  input  wire logic         i_power_set,         // power-set bit
  output logic              o_twi_enable,        // 2-wire core may run
  output logic              o_sda_out,           // sda output level
  output logic              o_sda_oe,            // sda pulled low
  output logic              o_select_pullup_en,  // select pull-up on
  output logic              o_settings_reset,    // settings to default
  output logic              o_low_power,         // low power level
  output logic              o_module_present_n,  // presence pin
  output logic              o_interrupt_n_out,   // interrupt level
  output logic              o_interrupt_n_oe,    // interrupt pulled low
  output logic [7:0]        o_status2            // status byte 2
);

  msc_pins_type            raw_pins;
  msc_pins_type            pins;
  logic                    reset_hold;
  logic                    reset_release;

  msc_state_type           state;
  msc_state_type           next_state;
  logic [INIT_CNT_W-1:0]   init_cnt;
  logic [INIT_CNT_W-1:0]   next_init_cnt;
  logic                    dnr;
  logic                    next_dnr;
  msc_flags_type           flags;
  msc_flags_type           next_flags;

  logic                    next_twi_enable;
  logic                    next_sda_oe;
  logic                    next_settings_reset;
  logic                    next_low_power;
  logic                    next_int_oe;

  assign raw_pins = '{
    select_n:  i_module_select_pin_n,
    reset_n:   i_module_reset_n,
    low_power: i_low_power_request
  };

  // pins enter the clock domain through two flops
  msc_pin_conditioner u_cond (
    .i_clk_sys       (i_clk_sys),
    .i_rst           (i_rst),
    .i_pins          (raw_pins),
    .o_pins          (pins),
    .o_reset_hold    (reset_hold),
    .o_reset_release (reset_release)
  );

  // reset and initialisation sequencing
  always_comb begin
    next_state    = state;
    next_init_cnt = init_cnt;
    next_dnr      = dnr;
    case (state)
      ST_HOLD: begin
        next_dnr      = 1'b1;
        next_init_cnt = '0;
        if (reset_release)
          next_state = ST_INIT;
      end
      ST_INIT: begin
        next_init_cnt = init_cnt + INIT_CNT_W'(1);
        if (reset_hold) begin
          next_state = ST_HOLD;
        end else if (i_monitor_valid ||
                     init_cnt == INIT_CNT_W'(INIT_LIMIT - 1)) begin
          // deadline keeps a stuck monitor from hiding the module
          next_state = ST_READY;
          next_dnr   = 1'b0;
        end
      end
      ST_READY: begin
        if (reset_hold) begin
          next_state = ST_HOLD;
          next_dnr   = 1'b1;
        end
      end
      default: begin
        next_state = ST_HOLD;
        next_dnr   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state    <= ST_INIT;
      init_cnt <= '0;
      dnr      <= 1'b1;
    end else begin
      state    <= next_state;
      init_cnt <= next_init_cnt;
      dnr      <= next_dnr;
    end
  end

  // sticky flags: a set in the read cycle survives
  always_comb begin
    next_flags = flags;
    if (i_flag_read)
      next_flags = '0;
    if (i_fault_event)
      next_flags.fault = 1'b1;
    if (state == ST_INIT && next_state == ST_READY)
      next_flags.complete = 1'b1;
    if (next_state == ST_HOLD)
      next_flags = '0;
    next_int_oe = |next_flags;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flags            <= '0;
      o_interrupt_n_oe <= 1'b0;
    end else begin
      flags            <= next_flags;
      o_interrupt_n_oe <= next_int_oe;
    end
  end

  // select gating, power level and settings reset
  always_comb begin
    next_twi_enable     = ~pins.select_n;
    next_sda_oe         = ~pins.select_n & i_twi_sda_pull;
    next_settings_reset = (next_state == ST_HOLD);
    if (i_power_override)
      next_low_power = i_power_set;
    else
      next_low_power = pins.low_power;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_twi_enable     <= 1'b0;
      o_sda_oe         <= 1'b0;
      o_settings_reset <= 1'b1;
      o_low_power      <= 1'b1;
    end else begin
      o_twi_enable     <= next_twi_enable;
      o_sda_oe         <= next_sda_oe;
      o_settings_reset <= next_settings_reset;
      o_low_power      <= next_low_power;
    end
  end

  // fixed pin levels; open-drain outputs only ever drive low
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out          <= 1'b0;
      o_interrupt_n_out  <= 1'b0;
      o_module_present_n <= PRESENT_LEVEL;
      o_select_pullup_en <= 1'b1;
    end else begin
      o_sda_out          <= 1'b0;
      o_interrupt_n_out  <= 1'b0;
      o_module_present_n <= PRESENT_LEVEL;
      o_select_pullup_en <= 1'b1;
    end
  end

  assign o_status2 = STATUS2_RESET & {7'h00, dnr};

  default clocking cb_sys @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_init_done;
    state == ST_INIT ##1 state == ST_READY;
  endsequence

  sequence s_released;
    reset_release ##1 state == ST_INIT;
  endsequence

  property p_select_ignore;
    pins.select_n |=> !o_sda_oe && !o_twi_enable;
  endproperty
  a_select_ignore: assert property (p_select_ignore)
    else $error("data line driven while deselected");

  property p_select_answer;
    !pins.select_n && i_twi_sda_pull |=> o_sda_oe && o_twi_enable;
  endproperty
  a_select_answer: assert property (p_select_answer)
    else $error("selected module did not drive data line");

  property p_complete;
    s_init_done |-> o_interrupt_n_oe && !o_status2[STATUS2_DNR_BIT];
  endproperty
  a_complete: assert property (p_complete)
    else $error("completion without interrupt and cleared bit");

  property p_restart;
    s_released |-> init_cnt == '0 ##1 init_cnt == INIT_CNT_W'(1);
  endproperty
  a_restart: assert property (p_restart)
    else $error("init timing not started at reset release");

  property p_dnr_state;
    (state == ST_READY) == !o_status2[STATUS2_DNR_BIT];
  endproperty
  a_dnr_state: assert property (p_dnr_state)
    else $error("not-ready bit disagrees with state");

  property p_pin_power;
    !i_power_override |=> o_low_power == $past(pins.low_power);
  endproperty
  a_pin_power: assert property (p_pin_power)
    else $error("pin did not choose power level");

  property p_set_power;
    i_power_override |=> o_low_power == $past(i_power_set);
  endproperty
  a_set_power: assert property (p_set_power)
    else $error("power-set bit did not choose power level");

  property p_read_release;
    i_flag_read && !i_fault_event && state != ST_INIT
      |=> !o_interrupt_n_oe;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("interrupt held after flags read");

  property p_hold_defaults;
    reset_hold |=> o_settings_reset && !o_interrupt_n_oe;
  endproperty
  a_hold_defaults: assert property (p_hold_defaults)
    else $error("settings not reset during module reset");

  property p_fixed_pins;
    o_module_present_n == PRESENT_LEVEL && o_interrupt_n_out == 1'b0;
  endproperty
  a_fixed_pins: assert property (p_fixed_pins)
    else $error("presence or interrupt level wrong");

  property p_fault_int;
    i_fault_event |=> o_interrupt_n_oe || state == ST_HOLD;
  endproperty
  a_fault_int: assert property (p_fault_int)
    else $error("fault did not pull interrupt low");

endmodule

//--- verif/msc_host_model.sv
module msc_host_model
  import msc_pkg::*;
(
  input  wire logic         i_release_select,   // host floats select
  input  wire msc_pins_type i_cmd,              // levels host drives
  input  wire logic         i_select_pullup_en, // module pull-up on
  input  wire logic         i_module_present_n, // module presence pin
  input  wire logic         i_interrupt_n_out,  // module int level
  input  wire logic         i_interrupt_n_oe,   // module pulls int
  input  wire logic         i_sda_out,          // module sda level
  input  wire logic         i_sda_oe,           // module pulls sda
  output logic              o_select_n,         // select wire
  output logic              o_reset_n,          // reset wire
  output logic              o_low_power,        // low power wire
  output logic              o_interrupt_n,      // int wire level
  output logic              o_present_n,        // presence wire
  output logic              o_sda               // sda wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // a floating select without the pull-up reads as selected
  assign o_select_n = i_release_select ? i_select_pullup_en
                                       : i_cmd.select_n;
  assign o_reset_n = i_cmd.reset_n;
  assign o_low_power = i_cmd.low_power;
  // host pull-ups: only a low pulled by the module wins
  assign o_interrupt_n = (i_interrupt_n_oe === 1'b1)
                         ? i_interrupt_n_out : 1'b1;
  assign o_present_n = (i_module_present_n === 1'b0) ? 1'b0 : 1'b1;
  assign o_sda = (i_sda_oe === 1'b1) ? i_sda_out : 1'b1;
endmodule

//--- verif/msc_sideband_tb.sv
module msc_sideband_tb
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 100;
  // rows: override, power-set, pin, expected low power
  localparam logic [3:0] ROWS [8] = '{
    4'b0011, 4'b0100, 4'b0000, 4'b0111,
    4'b1101, 4'b1111, 4'b1000, 4'b1010};
  logic         clk;
  logic         rst;
  logic         rel;
  msc_pins_type cmd;
  logic         pull;
  logic         valid;
  logic         fault;
  logic         rd;
  logic         ovr;
  logic         pset;
  logic         sel_w;
  logic         rst_w;
  logic         lp_w;
  logic         int_w;
  logic         prs_w;
  logic         sda_w;
  logic         twi_en;
  logic         sda_out;
  logic         sda_oe;
  logic         pu_en;
  logic         set_rst;
  logic         low_pwr;
  logic         prs_n;
  logic         int_out;
  logic         int_oe;
  logic [7:0]   status2;
  int           fails;
  int           n_tests;

  msc_sideband #(.INIT_LIMIT(LIMIT)) uut (
    .i_clk_sys(clk), .i_rst(rst), .i_module_select_pin_n(sel_w),
    .i_module_reset_n(rst_w), .i_low_power_request(lp_w),
    .i_twi_sda_pull(pull), .i_monitor_valid(valid),
    .i_fault_event(fault), .i_flag_read(rd),
    .i_power_override(ovr), .i_power_set(pset),
    .o_twi_enable(twi_en), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_select_pullup_en(pu_en), .o_settings_reset(set_rst),
    .o_low_power(low_pwr), .o_module_present_n(prs_n),
    .o_interrupt_n_out(int_out), .o_interrupt_n_oe(int_oe),
    .o_status2(status2));

  msc_host_model host (
    .i_release_select(rel), .i_cmd(cmd), .i_select_pullup_en(pu_en),
    .i_module_present_n(prs_n), .i_interrupt_n_out(int_out),
    .i_interrupt_n_oe(int_oe), .i_sda_out(sda_out),
    .i_sda_oe(sda_oe), .o_select_n(sel_w), .o_reset_n(rst_w),
    .o_low_power(lp_w), .o_interrupt_n(int_w),
    .o_present_n(prs_w), .o_sda(sda_w));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // completion: status byte cleared and interrupt pulled low
  task automatic wait_int(input int n);
    for (int i = 0; i < n && int_w !== 1'b0; i++) begin
      @(negedge clk);
    end
    chk("int_n", 8'h00, {7'h0, int_w});
    chk("status2", 8'h00, status2);
  endtask

  task automatic pulse(input logic f, input logic r);
    fault = f;
    rd = r;
    @(negedge clk);
    fault = 1'b0;
    rd = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    #(5000 * 40);
    fails++;
    wrap_up();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    {rel, pull, valid, fault, rd, ovr, pset} = '0;
    cmd = PINS_IDLE;
    rst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      repeat (12) @(negedge clk);
      if (i == 0) begin
        rst = 1'b0;
        wait_int(LIMIT + 20);
        pulse(1'b0, 1'b1);
        chk("int_n", 8'h01, {7'h0, int_w});
      end
      {ovr, pset, cmd.low_power} = ROWS[i][3:1];
      repeat (4) @(negedge clk);
      chk("low_power", {7'h0, ROWS[i][0]}, {7'h0, low_pwr});
    end
    pulse(1'b1, 1'b0);
    chk("int_n", 8'h00, {7'h0, int_w});
    pulse(1'b1, 1'b1);
    chk("int_n", 8'h00, {7'h0, int_w});
    pulse(1'b0, 1'b1);
    chk("int_n", 8'h01, {7'h0, int_w});
    pull = 1'b1;
    repeat (4) @(negedge clk);
    chk("twi_en", 8'h00, {7'h0, twi_en});
    chk("sda", 8'h01, {7'h0, sda_w});
    cmd.select_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("twi_en", 8'h01, {7'h0, twi_en});
    chk("sda", 8'h00, {7'h0, sda_w});
    rel = 1'b1;
    repeat (4) @(negedge clk);
    chk("twi_en", 8'h00, {7'h0, twi_en});
    chk("sda_oe", 8'h00, {7'h0, sda_oe});
    rel = 1'b0;
    chk("present_n", 8'h00, {7'h0, prs_w});
    cmd.reset_n = 1'b0;
    repeat (40) @(negedge clk);
    cmd.reset_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("settings_reset", 8'h00, {7'h0, set_rst});
    chk("status2", 8'h00, status2);
    // pending fault so the module reset has an interrupt to release
    pulse(1'b1, 1'b0);
    chk("int_n", 8'h00, {7'h0, int_w});
    cmd.reset_n = 1'b0;
    repeat (LIMIT + 50) @(negedge clk);
    // status read here only to see not-ready, other bits disregarded
    chk("settings_reset", 8'h01, {7'h0, set_rst});
    chk("status2", 8'h01, status2 & 8'h01);
    chk("int_n", 8'h01, {7'h0, int_w});
    cmd.reset_n = 1'b1;
    repeat (LIMIT / 2) @(negedge clk);
    chk("status2", 8'h01, status2);
    valid = 1'b1;
    wait_int(5);
    wrap_up();
  end
endmodule
